// File: rtl/rt_mode_msg_pingpong_buffer.sv
// Mode command message storage and double-buffer engine with AXI4-Lite host access.
`timescale 1ns/100ps
`include "rt_mode_msg_defines.svh"
module rt_mode_msg_pingpong_buffer #(
  parameter int RAM_WORDS = 1024,
  parameter int AW        = 10
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        msgStart,
  input  wire logic [15:0] descAddr,
  input  wire logic [4:0]  cmdModeCode,
  input  wire logic        cmdTransmit,
  input  wire logic        cmdBroadcast,
  input  wire logic        cmdBusB,
  input  wire logic        illegalHit,
  input  wire logic        msgDone,
  input  wire logic        gap_error_flag,
  input  wire logic        wordCountErr,
  input  wire logic [15:0] timeTag,
  input  wire logic [15:0] internalWord,
  output logic [15:0]      txDataWord,
  output logic             txDataValid,
  output logic             engineBusy
);

  // --------------------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------------------
  logic [15:0]                 ram [RAM_WORDS];
  rt_mode_msg_pkg::state_t     state_r;
  rt_mode_msg_pkg::state_t     state_nxt;
  logic [7:0]                  initIdx_r;
  logic [2:0]                  cfg_r;
  logic [AW-1:0]               desc_r;
  logic [AW-1:0]               ptr_r;
  logic [4:0]                  mc_r;
  logic                        tx_r;
  logic                        bcast_r;
  logic                        busB_r;
  logic                        illegal_r;
  logic                        busy_r;
  logic                        gap_r;
  logic                        wct_r;
  logic [15:0]                 txDataWord_r;
  logic                        txDataValid_r;
  logic                        engWe;
  logic [AW-1:0]               engAddr;
  logic [15:0]                 engData;
  logic [15:0]                 ctrlWord;
  logic                        okMsg;
  logic                        useBcast;
  logic                        internalCode;

  function automatic logic [AW-1:0] ramIdx(input logic [15:0] a);
    ramIdx = a[AW-1:0];
  endfunction

  function automatic logic [AW-1:0] offsetIdx(input logic [AW-1:0] b, input logic [1:0] o);
    offsetIdx = b + AW'(o);
  endfunction

  function automatic logic [15:0] statusWord(input logic gap, input logic wct,
                                             input logic busy, input logic ill,
                                             input logic bus, input logic [4:0] mc);
    statusWord                = 16'h0000;
    statusWord[`ST_GAP]       = gap;
    statusWord[`ST_WCT]       = wct;
    statusWord[`ST_MESSAGE_ERROR_FLAG]      = gap | wct;
    statusWord[`ST_BUSY]      = busy;
    statusWord[`ST_ILLEGAL]   = ill;
    statusWord[`ST_BUS]       = bus;
    statusWord[4:0]           = mc;
  endfunction

  function automatic logic [15:0] ackWord(input logic [15:0] c);
    ackWord           = c;
    ackWord[`CTL_ACK] = c[`CTL_SELECT] & ~c[`CTL_SUSPEND];
  endfunction

  // --------------------------------------------------------------------------
  // Message engine
  // --------------------------------------------------------------------------
  assign ctrlWord     = ram[desc_r];
  assign useBcast     = bcast_r & cfg_r[`CFG_BCAST_SEP];
  assign okMsg        = ~(gap_r | wct_r) & ~busy_r & ~illegal_r;
  assign internalCode = (mc_r == `MC_LAST_CMD) || (mc_r == `MC_SELFTEST);
  assign engineBusy   = (state_r != rt_mode_msg_pkg::S_IDLE);
  assign txDataWord   = txDataWord_r;
  assign txDataValid  = txDataValid_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rt_mode_msg_pkg::S_INIT: begin
        if (initIdx_r == `DESC_COUNT - 8'h01) begin
          state_nxt = rt_mode_msg_pkg::S_IDLE;
        end
      end
      rt_mode_msg_pkg::S_IDLE: begin
        if (msgStart) begin
          state_nxt = rt_mode_msg_pkg::S_CTRL;
        end
      end
      rt_mode_msg_pkg::S_CTRL:  state_nxt = rt_mode_msg_pkg::S_FETCH;
      rt_mode_msg_pkg::S_FETCH: state_nxt = rt_mode_msg_pkg::S_WAIT;
      rt_mode_msg_pkg::S_WAIT: begin
        if (msgDone) begin
          state_nxt = rt_mode_msg_pkg::S_STAT;
        end
      end
      rt_mode_msg_pkg::S_STAT:  state_nxt = rt_mode_msg_pkg::S_TTAG;
      rt_mode_msg_pkg::S_TTAG: begin
        if (tx_r && mc_r[4] && internalCode && !busy_r && !illegal_r && !useBcast) begin
          state_nxt = rt_mode_msg_pkg::S_DATA;
        end else begin
          state_nxt = rt_mode_msg_pkg::S_POST;
        end
      end
      rt_mode_msg_pkg::S_DATA:  state_nxt = rt_mode_msg_pkg::S_POST;
      rt_mode_msg_pkg::S_POST:  state_nxt = rt_mode_msg_pkg::S_IDLE;
      default:                  state_nxt = rt_mode_msg_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= rt_mode_msg_pkg::S_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      initIdx_r <= 8'h00;
    end else if (state_r == rt_mode_msg_pkg::S_INIT) begin
      initIdx_r <= initIdx_r + 8'h01;
    end
  end

  // The engine owns the RAM write port in these states; the host waits meanwhile.
  always_comb begin
    engWe   = 1'b0;
    engAddr = desc_r;
    engData = 16'h0000;
    case (state_r)
      rt_mode_msg_pkg::S_INIT: begin
        engWe   = 1'b1;
        engAddr = ramIdx(`DESC_BASE + {6'h00, initIdx_r, 2'h0});
        engData = ram[engAddr] & ~(16'h0001 << `CTL_NEXT_SEL);
      end
      rt_mode_msg_pkg::S_CTRL: begin
        engWe   = 1'b1;
        engData = ackWord(ctrlWord);
      end
      rt_mode_msg_pkg::S_STAT: begin
        engWe   = 1'b1;
        engAddr = ptr_r;
        engData = statusWord(gap_r, wct_r, busy_r, illegal_r, busB_r, mc_r);
      end
      rt_mode_msg_pkg::S_TTAG: begin
        engWe   = 1'b1;
        engAddr = offsetIdx(ptr_r, `OFS_TIME_TAG);
        engData = timeTag;
      end
      rt_mode_msg_pkg::S_DATA: begin
        engWe   = 1'b1;
        engAddr = offsetIdx(ptr_r, `OFS_MODE_DATA);
        engData = txDataWord_r;
      end
      rt_mode_msg_pkg::S_POST: begin
        engWe   = 1'b1;
        engData = ackWord(ctrlWord);
        // Suspended, separated-broadcast or failed messages keep the same buffer.
        if (ctrlWord[`CTL_SELECT] && !ctrlWord[`CTL_SUSPEND] && okMsg && !useBcast) begin
          engData[`CTL_NEXT_SEL] = ~ctrlWord[`CTL_NEXT_SEL];
        end
      end
      default: begin
        engWe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      desc_r    <= '0;
      mc_r      <= 5'h00;
      tx_r      <= 1'b0;
      bcast_r   <= 1'b0;
      busB_r    <= 1'b0;
      illegal_r <= 1'b0;
    end else if (state_r == rt_mode_msg_pkg::S_IDLE && msgStart) begin
      desc_r    <= ramIdx(descAddr);
      mc_r      <= cmdModeCode;
      tx_r      <= cmdTransmit;
      bcast_r   <= cmdBroadcast;
      busB_r    <= cmdBusB;
      illegal_r <= illegalHit | (cfg_r[`CFG_UNDEF_INV] & cmdTransmit &
                   (cmdModeCode == `MC_UNDEF_A || cmdModeCode == `MC_UNDEF_B ||
                    cmdModeCode == `MC_UNDEF_C));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ptr_r  <= '0;
      busy_r <= 1'b0;
    end else if (state_r == rt_mode_msg_pkg::S_CTRL) begin
      busy_r <= cfg_r[`CFG_GLOBAL_BUSY] | ctrlWord[`CTL_FORCE_BUSY];
      if (useBcast) begin
        ptr_r <= ramIdx(ram[offsetIdx(desc_r, `DESC_PTR_BCAST)]);
      end else if (ctrlWord[`CTL_SELECT] && ctrlWord[`CTL_NEXT_SEL]) begin
        ptr_r <= ramIdx(ram[offsetIdx(desc_r, `DESC_PTR_B)]);
      end else begin
        ptr_r <= ramIdx(ram[offsetIdx(desc_r, `DESC_PTR_A)]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txDataWord_r  <= 16'h0000;
      txDataValid_r <= 1'b0;
    end else if (state_r == rt_mode_msg_pkg::S_FETCH) begin
      txDataWord_r  <= internalCode ? internalWord : ram[offsetIdx(ptr_r, `OFS_MODE_DATA)];
      txDataValid_r <= tx_r & mc_r[4] & ~busy_r & ~illegal_r & ~useBcast;
    end else if (state_r == rt_mode_msg_pkg::S_WAIT && msgDone) begin
      txDataValid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gap_r <= 1'b0;
      wct_r <= 1'b0;
    end else if (state_r == rt_mode_msg_pkg::S_WAIT && msgDone) begin
      gap_r <= gap_error_flag;
      wct_r <= wordCountErr;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        hostWin;
  logic        wrTake;
  logic [15:0] wrMask;

  assign hostWin = (state_r == rt_mode_msg_pkg::S_IDLE) || (state_r == rt_mode_msg_pkg::S_WAIT);
  assign wrTake  = awvalid & wvalid & ~bvalid_r & hostWin;
  assign awready = wrTake;
  assign wready  = wrTake;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = ~rvalid_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;
  assign wrMask  = {{8{wstrb[1]}}, {8{wstrb[0]}}};

  always_ff @(posedge sys_clk) begin
    if (engWe) begin
      ram[engAddr] <= engData;
    end else if (wrTake && awaddr < `RAM_BYTE_LIMIT) begin
      ram[awaddr[AW+1:2]] <= (ram[awaddr[AW+1:2]] & ~wrMask) | (wdata[15:0] & wrMask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_r <= `CFG_RESET;
    end else if (wrTake && awaddr[15:2] == `CFG_OFFSET >> 2 && wstrb[0]) begin
      cfg_r <= wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
    end else if (wrTake) begin
      bvalid_r <= 1'b1;
      if (awaddr < `RAM_BYTE_LIMIT || awaddr[15:2] == `CFG_OFFSET >> 2 ||
          awaddr[15:2] == `STATUS_OFFSET >> 2) begin
        bresp_r <= 2'h0;
      end else begin
        bresp_r <= 2'h3;
      end
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rresp_r  <= 2'h0;
      rdata_r  <= 32'h00000000;
    end else if (arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= 2'h0;
      if (araddr < `RAM_BYTE_LIMIT) begin
        rdata_r <= {16'h0000, ram[araddr[AW+1:2]]};
      end else if (araddr[15:2] == `CFG_OFFSET >> 2) begin
        rdata_r <= {29'h00000000, cfg_r};
      end else if (araddr[15:2] == `STATUS_OFFSET >> 2) begin
        rdata_r <= {15'h0000, engineBusy, statusWord(gap_r, wct_r, busy_r, illegal_r,
                                                     busB_r, mc_r)};
      end else begin
        rdata_r <= 32'h00000000;
        rresp_r <= 2'h3;
      end
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence statusWrite;
    state_r == rt_mode_msg_pkg::S_STAT && engWe && engAddr == ptr_r;
  endsequence

  sequence tagWrite;
    engWe && engAddr == offsetIdx(ptr_r, `OFS_TIME_TAG) && engData == timeTag;
  endsequence

  a_store_order_layout: assert property (@(posedge sys_clk) disable iff (reset)
    statusWrite |=> tagWrite)
    else $error("Time-tag not stored right after status word.");

  a_unused_bits_zero: assert property (@(posedge sys_clk) disable iff (reset)
    statusWrite |-> engData[15:14] == 2'h0 && !engData[11] && engData[7:6] == 2'h0)
    else $error("Unused status word bits not zero.");

  a_mode_code_copy: assert property (@(posedge sys_clk) disable iff (reset)
    statusWrite |-> engData[4:0] == mc_r && engData[`ST_BUS] == busB_r)
    else $error("Mode code or bus bit wrong in status word.");

  a_message_error_flag_summary: assert property (@(posedge sys_clk) disable iff (reset)
    statusWrite |-> engData[`ST_MESSAGE_ERROR_FLAG] == (engData[`ST_GAP] | engData[`ST_WCT]))
    else $error("Message error bit disagrees with gap and count bits.");

  a_busy_no_data: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == rt_mode_msg_pkg::S_FETCH && busy_r) |=> !txDataValid_r)
    else $error("Mode data offered despite busy reply.");

  a_ack_follows_ctrl: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == rt_mode_msg_pkg::S_CTRL |-> engData[`CTL_ACK] ==
      (ctrlWord[`CTL_SELECT] & ~ctrlWord[`CTL_SUSPEND]))
    else $error("Acknowledge bit does not follow select and suspend.");

  a_hold_on_fail: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == rt_mode_msg_pkg::S_POST && (!okMsg || ctrlWord[`CTL_SUSPEND] || useBcast))
      |-> engData[`CTL_NEXT_SEL] == ctrlWord[`CTL_NEXT_SEL])
    else $error("Next-pointer bit toggled when it must hold.");

  a_toggle_on_ok: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == rt_mode_msg_pkg::S_POST && okMsg && ctrlWord[`CTL_SELECT] &&
     !ctrlWord[`CTL_SUSPEND] && !useBcast)
      |-> engData[`CTL_NEXT_SEL] != ctrlWord[`CTL_NEXT_SEL])
    else $error("Next-pointer bit not toggled after good message.");

  a_init_clears: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == rt_mode_msg_pkg::S_INIT) |-> engWe && !engData[`CTL_NEXT_SEL])
    else $error("Descriptor sweep left next-pointer bit set.");

  a_internal_copy: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == rt_mode_msg_pkg::S_DATA |-> internalCode &&
      engAddr == offsetIdx(ptr_r, `OFS_MODE_DATA) && engData == txDataWord_r)
    else $error("Internal data word not copied to structure.");

endmodule

// File: rtl/rt_mode_msg_defines.svh
// Offsets, field positions, reset values and sizes of the mode message buffer block.
// Operation
// - Data mode codes store status, time-tag, data word
// - Last-command and self-test words copied after completion
// - Undefined data codes answer unless invalidated
// - No-data mode codes store status, time-tag only
// - Status bit 13 flags gap error
// - Status bit 12 flags unexpected data words
// - Status bit 10 flags any message error
// - Status bit 9 flags busy, no data sent
// - Status bit 8 flags illegal command
// - Status bit 5 records bus A or B
// - Status bits 4-0 hold the mode code
// - Double buffering alternates buffers per message
// - Descriptor holds control, pointer A, B, broadcast
// - Select set, suspend clear sets acknowledge
// - Next-pointer bit picks pointer A or B
// - Toggle next-pointer only after error-free message
// - Suspend clears acknowledge, protects last buffer
// - Suspended messages reuse the same active buffer
// - Resume sets acknowledge and alternation again
// - Reset clears every next-pointer bit
// - Separated broadcasts use broadcast buffer, no toggle
`ifndef RT_MODE_MSG_DEFINES_SVH
`define RT_MODE_MSG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RAM_BYTE_LIMIT  16'h1000
`define CFG_OFFSET      16'h1000
`define STATUS_OFFSET   16'h1004

// ----------------------------------------------------------------------------
// Configuration and status fields
// ----------------------------------------------------------------------------
`define CFG_UNDEF_INV   0
`define CFG_BCAST_SEP   1
`define CFG_GLOBAL_BUSY 2
`define CFG_RESET       3'h0
`define STS_BUSY        16

// ----------------------------------------------------------------------------
// Descriptor control word fields and descriptor layout
// ----------------------------------------------------------------------------
`define CTL_NEXT_SEL    4
`define CTL_ACK         5
`define CTL_SUSPEND     6
`define CTL_SELECT      7
`define CTL_FORCE_BUSY  13
`define DESC_PTR_A      2'h1
`define DESC_PTR_B      2'h2
`define DESC_PTR_BCAST  2'h3
`define DESC_BASE       16'h0000
`define DESC_COUNT      8'h80

// ----------------------------------------------------------------------------
// Data structure offsets and status word fields
// ----------------------------------------------------------------------------
`define OFS_TIME_TAG    2'h1
`define OFS_MODE_DATA   2'h2
`define ST_GAP          13
`define ST_WCT          12
`define ST_MESSAGE_ERROR_FLAG         10
`define ST_BUSY         9
`define ST_ILLEGAL      8
`define ST_BUS          5
`define MC_LAST_CMD     5'h12
`define MC_SELFTEST     5'h13
`define MC_UNDEF_A      5'h11
`define MC_UNDEF_B      5'h14
`define MC_UNDEF_C      5'h15

`endif

// File: rtl/rt_mode_msg_pkg.sv
// Types of the mode message buffer block.
package rt_mode_msg_pkg;
  typedef enum logic [3:0] {
    S_INIT  = 4'h0,
    S_IDLE  = 4'h1,
    S_CTRL  = 4'h2,
    S_FETCH = 4'h3,
    S_WAIT  = 4'h4,
    S_STAT  = 4'h5,
    S_TTAG  = 4'h6,
    S_DATA  = 4'h7,
    S_POST  = 4'h8
  } state_t;
endpackage

// File: test/bc_model.sv
// Bus controller model that issues transmit mode commands to the message engine.
`timescale 1ns/100ps
module bc_model (
  input  wire logic        sys_clk,
  input  wire logic        engineBusy,
  input  wire logic        txDataValid,
  input  wire logic [15:0] txDataWord,
  output logic             msgStart,
  output logic [15:0]      descAddr,
  output logic [4:0]       cmdModeCode,
  output logic             cmdTransmit,
  output logic             cmdBroadcast,
  output logic             cmdBusB,
  output logic             illegalHit,
  output logic             msgDone,
  output logic             gap_error_flag,
  output logic             wordCountErr,
  output logic [15:0]      timeTag,
  output logic [15:0]      internalWord
);
  initial begin
    {msgStart, msgDone, cmdTransmit, cmdBroadcast, cmdBusB, illegalHit} = '0;
    {gap_error_flag, wordCountErr, descAddr, cmdModeCode, timeTag, internalWord} = '0;
  end

  // Flags f are broadcast, bus B, illegal, gap error, word count error.
  // Command fields are inverted once taken, so a late sample shows up as wrong data.
  task automatic send(input logic [15:0] desc, input logic [4:0] code, input logic [4:0] f,
                      input logic [15:0] tt, input int slow,
                      output logic saw, output logic [15:0] word, output logic ok);
    int n;
    n = 0;
    while (engineBusy && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    ok = (n < 300);
    msgStart <= 1'b1;
    {descAddr, cmdModeCode, cmdTransmit, cmdBroadcast, cmdBusB, illegalHit} <=
      {desc, code, 1'b1, f[4:2]};
    {timeTag, internalWord} <= {tt, ~tt};
    @(posedge sys_clk);
    msgStart <= 1'b0;
    {descAddr, cmdModeCode, cmdTransmit, cmdBroadcast, cmdBusB, illegalHit} <=
      ~{desc, code, 1'b1, f[4:2]};
    repeat (4 + slow) @(posedge sys_clk);
    saw = txDataValid;
    word = txDataWord;
    {msgDone, gap_error_flag, wordCountErr} <= {1'b1, f[1:0]};
    @(posedge sys_clk);
    {msgDone, gap_error_flag, wordCountErr} <= {1'b0, ~f[1:0]};
    n = 0;
    do @(posedge sys_clk); while (engineBusy && ++n < 300);
    ok = ok && (n < 300);
    {timeTag, internalWord} <= {~tt, tt};
  endtask
endmodule

// File: test/tb.sv
// Self-checking testbench of the mode message double-buffer engine.
`timescale 1ns/100ps
`include "rt_mode_msg_defines.svh"
module tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = 4'h3;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, txDataValid, engineBusy;
  logic [1:0]  bresp, rresp, wresp;
  logic [31:0] rdata;
  logic [15:0] descAddr, timeTag, internalWord, txDataWord;
  logic [4:0]  cmdModeCode;
  logic        msgStart, cmdTransmit, cmdBroadcast, cmdBusB, illegalHit;
  logic        msgDone, gap_error_flag, wordCountErr;
  logic        side = 1'b0;
  int          bad_count = 0;
  int          num_checks = 0;
  localparam logic [15:0] DESC = 16'h0008, PA = 16'h0100, PB = 16'h0110, PBC = 16'h0120;

  always #5 sys_clk = ~sys_clk;

  rt_mode_msg_pingpong_buffer rt_mode_msg_pingpong_buffer_i (.sys_clk, .reset, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .msgStart, .descAddr, .cmdModeCode,
    .cmdTransmit, .cmdBroadcast, .cmdBusB, .illegalHit, .msgDone, .gap_error_flag, .wordCountErr,
    .timeTag, .internalWord, .txDataWord, .txDataValid, .engineBusy);

  bc_model bc_model_i (.sys_clk, .engineBusy, .txDataValid, .txDataWord, .msgStart, .descAddr,
    .cmdModeCode, .cmdTransmit, .cmdBroadcast, .cmdBusB, .illegalHit, .msgDone, .gap_error_flag,
    .wordCountErr, .timeTag, .internalWord);

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic results;
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  function automatic logic [15:0] ba(input logic [15:0] w);
    return {w[13:0], 2'b00};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    {awvalid, wvalid} <= 2'h3;
    do @(posedge sys_clk); while (!(awready && wready) && ++n < 300);
    {awvalid, wvalid, bready} <= 3'h1;
    do @(posedge sys_clk); while (!bvalid && ++n < 300);
    wresp = bresp;
    bready <= 1'b0;
    if (n >= 300) begin
      bad_count++;
      results;
    end
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (!arready && ++n < 300);
    {arvalid, rready} <= 2'h1;
    do @(posedge sys_clk); while (!rvalid && ++n < 300);
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
    if (n >= 300) begin
      bad_count++;
      results;
    end
  endtask

  task automatic do_reset;
    int n;
    n = 0;
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    do @(posedge sys_clk); while (engineBusy && ++n < 400);
    if (n >= 400) begin
      bad_count++;
      results;
    end
  endtask

  task automatic setctl(input logic [15:0] b);
    wr(ba(DESC), b | {11'h000, side, 4'h0});
    chk("write resp", 16'h0000, {14'h0000, wresp});
  endtask

  // One message; x holds separation enabled, suspended, busy, invalidated code.
  task automatic msg(input logic [4:0] c, input logic [4:0] f, input logic [3:0] x,
                     input logic [15:0] tt);
    logic ill, bsy, sep, tx, tog, own, saw, ok;
    logic [15:0] p, w, ew, v;
    logic [1:0] r;
    ill = f[2] | x[0];
    bsy = x[1];
    sep = x[3] & f[4];
    own = (c == 5'h12) || (c == 5'h13);
    p = sep ? PBC : (side ? PB : PA);
    tx = c[4] & !bsy & !ill & !sep;
    tog = !(f[1] | f[0] | bsy | ill | x[2] | sep);
    ew = own ? ~tt : tt + 16'h0001;
    if (c[4] && !own) wr(ba(p + 16'h0002), ew);
    bc_model_i.send(DESC, c, f, tt, f[3] ? 5 : 0, saw, w, ok);
    if (!ok) begin
      bad_count++;
      results;
    end
    chk("tx valid", {15'h0000, tx}, {15'h0000, saw});
    if (tx) chk("tx word", ew, w);
    rd(ba(p), v, r);
    chk("status", {2'b00, f[1:0], 1'b0, |f[1:0], bsy, ill, 2'b00, f[3], c}, v);
    rd(ba(p + 16'h0001), v, r);
    chk("time tag", tt, v);
    if (own && tx) begin
      rd(ba(p + 16'h0002), v, r);
      chk("copied word", ~tt, v);
    end
    side = side ^ tog;
    rd(ba(DESC), v, r);
    chk("next pointer", {15'h0000, side}, {15'h0000, v[4]});
    chk("active ack", {15'h0000, !x[2]}, {15'h0000, v[5]});
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_pingpong;
    wr(ba(DESC + 16'h0001), PA);
    wr(ba(DESC + 16'h0002), PB);
    wr(ba(DESC + 16'h0003), PBC);
    setctl(16'h0080);
    msg(5'h10, 5'h00, 4'h0, 16'h1000);
    msg(5'h10, 5'h08, 4'h0, 16'h2000);
    msg(5'h1F, 5'h00, 4'h0, 16'h3000);
  endtask

  task automatic t_errors;
    logic [15:0] v;
    logic [1:0] r;
    msg(5'h05, 5'h02, 4'h0, 16'h4000);
    msg(5'h00, 5'h01, 4'h0, 16'h4100);
    msg(5'h0F, 5'h00, 4'h0, 16'h4200);
    rd(ba(PB + 16'h0002), v, r);
    chk("kept word", 16'h2001, v);
  endtask

  task automatic t_busy;
    setctl(16'h2080);
    msg(5'h10, 5'h00, 4'h2, 16'h5000);
    setctl(16'h0080);
    wr(`CFG_OFFSET, 16'h0004);
    msg(5'h16, 5'h00, 4'h2, 16'h5100);
    wr(`CFG_OFFSET, 16'h0000);
  endtask

  task automatic t_illegal;
    logic [4:0] u [3] = '{5'h11, 5'h14, 5'h15};
    msg(5'h12, 5'h04, 4'h0, 16'h6000);
    msg(5'h13, 5'h00, 4'h0, 16'h6010);
    msg(5'h12, 5'h00, 4'h0, 16'h6020);
    for (int i = 0; i < 3; i++) begin
      wr(`CFG_OFFSET, 16'h0001);
      msg(u[i], 5'h00, 4'h1, 16'h6100 + 16'(i));
      wr(`CFG_OFFSET, 16'h0000);
      msg(u[i], 5'h00, 4'h0, 16'h6200 + 16'(i));
    end
  endtask

  task automatic t_suspend;
    logic [15:0] v, q;
    logic [1:0] r;
    setctl(16'h00C0);
    msg(5'h10, 5'h00, 4'h4, 16'h7000);
    q = side ? PA : PB;
    wr(ba(q), 16'hCAFE);
    msg(5'h10, 5'h00, 4'h4, 16'h7100);
    rd(ba(q), v, r);
    chk("idle buffer", 16'hCAFE, v);
    setctl(16'h0080);
    msg(5'h10, 5'h00, 4'h0, 16'h7200);
  endtask

  task automatic t_bcast;
    wr(`CFG_OFFSET, 16'h0002);
    msg(5'h10, 5'h10, 4'h8, 16'h8000);
    msg(5'h10, 5'h00, 4'h8, 16'h8100);
    wr(`CFG_OFFSET, 16'h0000);
  endtask

  task automatic t_reset;
    logic [15:0] v;
    logic [1:0] r;
    rd(16'h2000, v, r);
    chk("unmapped resp", 16'h0003, {14'h0000, r});
    chk("unmapped data", 16'h0000, v);
    wr(16'h2000, 16'h0000);
    chk("unmapped bresp", 16'h0003, {14'h0000, wresp});
    setctl(16'h0090);
    do_reset;
    side = 1'b0;
    rd(ba(DESC), v, r);
    chk("reset next", 16'h0000, {15'h0000, v[4]});
    msg(5'h10, 5'h00, 4'h0, 16'h9000);
    rd(`STATUS_OFFSET, v, r);
    chk("status image", 16'h0010, v);
    chk("status resp", 16'h0000, {14'h0000, r});
  endtask

  initial begin
    do_reset;
    t_pingpong;
    t_errors;
    t_busy;
    t_illegal;
    t_suspend;
    t_bcast;
    t_reset;
    results;
  end
endmodule
